// >>> hw/apo_pkg.sv
`default_nettype none
package apo_pkg;

    // ==========================================================
    // widths and clock
    // ==========================================================
    localparam int CODE_W = 12;
    localparam int ANA_W = 14;
    localparam int PIPE_DEPTH = 8;
    localparam int CLK_PS = 25000;

    // ==========================================================
    // timing, least times round up, longest round down
    // ==========================================================
    localparam int STROBE_DLY_PS = 6800;
    localparam int STROBE_DLY_CYC = (STROBE_DLY_PS + CLK_PS - 1) / CLK_PS;
    localparam int STROBE_LOW_PS = 50000;
    localparam int STROBE_LOW_CYC = STROBE_LOW_PS / CLK_PS;
    localparam int PD_FLOAT_PS = 10000;
    localparam int PD_FLOAT_CYC = (PD_FLOAT_PS / CLK_PS < 1) ? 1
                                  : PD_FLOAT_PS / CLK_PS;
    localparam int PD_WAKE_PS = 10000;
    localparam int PD_WAKE_CYC = (PD_WAKE_PS + CLK_PS - 1) / CLK_PS;
    localparam logic [6:0] LOCK_CYC = 7'h64;
    localparam int PER_W = 8;

    // ==========================================================
    // codes
    // ==========================================================
    localparam logic signed [ANA_W-1:0] POS_FS = 14'sh07FF;
    localparam logic signed [ANA_W-1:0] NEG_FS = -14'sh0800;
    localparam logic [CODE_W-1:0] MSB_FLIP = 12'h800;

    // ==========================================================
    // register map, byte addresses
    // ==========================================================
    localparam int ADR_W = 4;
    localparam logic [ADR_W-1:0] ADR_CTRL = 4'h0;
    localparam logic [ADR_W-1:0] ADR_STAT = 4'h4;
    localparam logic [ADR_W-1:0] ADR_DATA = 4'h8;
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam int STAT_LOCK = 0;
    localparam int STAT_OOR = 1;
    localparam int STAT_DRIVE = 2;
    localparam int STAT_OOR_SEEN = 3;

    typedef struct packed {
        logic pwr_down;
        logic gray_sel;
        logic dce_en;
        logic clk_diff;
    } apo_ctrl_t;

    typedef struct packed {
        logic oor;
        logic [CODE_W-1:0] code;
    } apo_word_t;

    typedef enum logic {APO_STB_HIGH, APO_STB_LOW} apo_stb_t;

endpackage
`default_nettype wire

// >>> hw/apo_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module apo_encoder (
    input wire logic signed [apo_pkg::ANA_W-1:0] analog_i,
    input wire logic gray_sel_i,
    output apo_pkg::apo_word_t word_o
);
    import apo_pkg::*;

    logic [CODE_W-1:0] twos;
    logic [CODE_W-1:0] offs;
    logic [CODE_W-1:0] gray;
    logic over;
    logic under;

    // ==========================================================
    // range check and clamp
    // ==========================================================
    assign over = analog_i > POS_FS; // see R10
    assign under = analog_i < NEG_FS; // see R10

    always_comb begin
        if (over) begin
            twos = POS_FS[CODE_W-1:0]; // see R20
        end else if (under) begin
            twos = NEG_FS[CODE_W-1:0]; // see R20
        end else begin
            twos = analog_i[CODE_W-1:0]; // see R17
        end
    end

    // ==========================================================
    // reflected binary of offset binary
    // ==========================================================
    assign offs = twos ^ MSB_FLIP; // see R19
    assign gray[CODE_W-1] = offs[CODE_W-1];
    for (genvar i = 0; i < CODE_W - 1; i++) begin : g_gray
        assign gray[i] = offs[i] ^ offs[i+1];
    end

    assign word_o.oor = over | under; // see R10 R11
    assign word_o.code = gray_sel_i ? gray : twos; // see R16

endmodule // apo_encoder
`default_nettype wire

// >>> hw/apo_delay_mem.sv
`timescale 1ns/1ps
`default_nettype none
module apo_delay_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire apo_pkg::apo_word_t wr_data_i,
    output apo_pkg::apo_word_t rd_data_o
);
    import apo_pkg::*;

    apo_word_t mem_q [PIPE_DEPTH];
    apo_word_t rd_q;
    logic [$clog2(PIPE_DEPTH)-1:0] ptr_q;

    // ==========================================================
    // circular delay, read before overwrite
    // ==========================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_q <= '0;
            ptr_q <= '0;
        end else if (en_i) begin
            mem_q[ptr_q] <= wr_data_i;
            rd_q <= mem_q[ptr_q];
            ptr_q <= ptr_q + 1'b1;
        end
    end

    assign rd_data_o = rd_q;

endmodule // apo_delay_mem
`default_nettype wire

// >>> hw/apo_top.sv
// How it works
// R01: select chooses single-ended or differential clock
// R02: analog sample taken on clock fall
// R03: result appears 8.5 clock cycles later
// R04: enable bit switches duty equaliser on
// R05: equaliser relocks 100 cycles after change
// R06: strobe from clock, data changes on fall
// R07: bypass: inverted delayed clock; else fixed width
// R08: back end captures on strobe rise
// R09: back end may capture on clock rise
// R10: flag high outside reference range
// R11: flag shares latency with its word
// R12: flag floats and wakes within 10ns; here each takes one 25ns clock cycle
// R13: data floats in power-down, wakes 10ns; here float and wake each take one 25ns clock cycle
// R14: strobe floats, clock legs ignored
// R15: twelve bit bus with output enable
// R16: gray when selected, else two's complement
// R17: code scaling against reference difference
// R18: power-down bit high stops conversion
// R19: gray is reflected offset binary
// R20: overrange clamps to full-scale code
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module apo_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [apo_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic clock_in_pos_i,
    input wire logic clock_in_neg_i,
    input wire logic signed [apo_pkg::ANA_W-1:0] analog_in_i,
    output logic [apo_pkg::CODE_W-1:0] result_bus_o,
    output logic result_bus_oe_n_o,
    output logic out_of_range_flag_o,
    output logic out_of_range_flag_oe_n_o,
    output logic data_valid_strobe_o,
    output logic data_valid_strobe_oe_n_o
);
    import apo_pkg::*;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    apo_ctrl_t ctrl_q;
    apo_word_t enc_w;
    apo_word_t sample_q;
    apo_word_t out_q;
    logic conv_d, conv_q;
    logic rise_evt, fall_evt;
    logic upd_q;
    logic drv_off_q;
    logic [1:0] pd_cnt_q;
    logic [1:0] pd_lim;
    apo_stb_t stb_st_q;
    logic [1:0] stb_cnt_q;
    logic strobe_q;
    logic [PER_W-1:0] per_cnt_q, last_per_q;
    logic [6:0] lock_cnt_q;
    logic dce_prev_q;
    logic relock;
    logic locked;
    logic oor_seen_q;
    logic req, ack_q;
    logic [31:0] dat_q;
    logic wr_stat;

    // ==========================================================
    // conversion clock from the legs
    // ==========================================================
    // legs are ignored in power-down, the clock freezes
    always_comb begin
        if (ctrl_q.pwr_down) begin
            conv_d = conv_q; // see R14
        end else if (ctrl_q.clk_diff) begin
            conv_d = clock_in_pos_i & ~clock_in_neg_i; // see R01
        end else begin
            conv_d = clock_in_pos_i; // see R01
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_q <= 1'b0;
        end else begin
            conv_q <= conv_d;
        end
    end

    assign rise_evt = conv_d & ~conv_q;
    assign fall_evt = ~conv_d & conv_q;

    // ==========================================================
    // sampling and pipeline
    // ==========================================================
    apo_encoder u_enc (
        .analog_i(analog_in_i),
        .gray_sel_i(ctrl_q.gray_sel),
        .word_o(enc_w)
    );

    // sample and flag travel as one word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_q <= '0;
        end else if (fall_evt) begin
            sample_q <= enc_w; // see R02 R10 R11
        end
    end

    // written at first rise, read at ninth: 8.5 cycles
    apo_delay_mem u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(rise_evt), // see R03
        .wr_data_i(sample_q),
        .rd_data_o(out_q)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upd_q <= 1'b0;
        end else begin
            upd_q <= rise_evt;
        end
    end

    assign result_bus_o = out_q.code; // see R15
    assign out_of_range_flag_o = out_q.oor; // see R11

    // ==========================================================
    // power-down output enables
    // ==========================================================
    assign pd_lim = ctrl_q.pwr_down ? 2'(PD_FLOAT_CYC) : 2'(PD_WAKE_CYC);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_off_q <= 1'b0;
            pd_cnt_q <= '0;
        end else if (ctrl_q.pwr_down != drv_off_q) begin
            if (pd_cnt_q == pd_lim - 2'd1) begin
                drv_off_q <= ctrl_q.pwr_down; // see R12 R13 R18
                pd_cnt_q <= '0;
            end else begin
                pd_cnt_q <= pd_cnt_q + 2'd1;
            end
        end else begin
            pd_cnt_q <= '0;
        end
    end

    assign result_bus_oe_n_o = drv_off_q; // see R13
    assign out_of_range_flag_oe_n_o = drv_off_q; // see R12
    assign data_valid_strobe_oe_n_o = drv_off_q; // see R14

    // ==========================================================
    // data-valid strobe
    // ==========================================================
    // falls at the edge where the word changes, rises mid-cycle in bypass, STROBE_LOW_CYC cycles later when equalised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stb_st_q <= APO_STB_HIGH;
            stb_cnt_q <= '0;
            strobe_q <= 1'b1;
        end else if (!ctrl_q.dce_en) begin
            stb_st_q <= APO_STB_HIGH;
            stb_cnt_q <= '0;
            strobe_q <= ~conv_d; // see R07
        end else begin
            case (stb_st_q)
                APO_STB_HIGH: begin
                    strobe_q <= 1'b1;
                    if (rise_evt) begin
                        stb_st_q <= APO_STB_LOW;
                        stb_cnt_q <= 2'(STROBE_LOW_CYC - 1);
                        strobe_q <= 1'b0; // see R06
                    end
                end
                APO_STB_LOW: begin
                    if (stb_cnt_q == 2'd0) begin
                        stb_st_q <= APO_STB_HIGH;
                        strobe_q <= 1'b1; // see R07
                    end else begin
                        stb_cnt_q <= stb_cnt_q - 2'd1;
                    end
                end
                default: begin
                    stb_st_q <= APO_STB_HIGH;
                    strobe_q <= 1'b1;
                end
            endcase
        end
    end

    assign data_valid_strobe_o = strobe_q; // see R06 R08

    // ==========================================================
    // equaliser lock tracking
    // ==========================================================
    // a new period or a fresh enable restarts the lock wait
    assign relock = rise_evt & ctrl_q.dce_en
                    & ((per_cnt_q != last_per_q) | ~dce_prev_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_cnt_q <= '0;
            last_per_q <= '0;
            dce_prev_q <= 1'b0;
        end else if (rise_evt) begin
            per_cnt_q <= '0;
            last_per_q <= per_cnt_q;
            dce_prev_q <= ctrl_q.dce_en;
        end else if (per_cnt_q != '1) begin
            per_cnt_q <= per_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_cnt_q <= '0;
        end else if (!ctrl_q.dce_en) begin
            lock_cnt_q <= '0; // see R04
        end else if (relock) begin
            lock_cnt_q <= LOCK_CYC; // see R05
        end else if (rise_evt && lock_cnt_q != '0) begin
            lock_cnt_q <= lock_cnt_q - 7'd1;
        end
    end

    assign locked = (lock_cnt_q == '0);

    // ==========================================================
    // wishbone slave
    // ==========================================================
    function automatic logic [31:0] rd_mux(
        input logic [ADR_W-1:0] adr, input apo_ctrl_t c,
        input logic [3:0] st, input apo_word_t w);
        rd_mux = 32'h0000_0000;
        case (adr)
            ADR_CTRL: rd_mux[CTRL_W-1:0] = c;
            ADR_STAT: rd_mux[3:0] = st;
            ADR_DATA: rd_mux[CODE_W:0] = w;
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    assign req = wb_cyc_i & wb_stb_i;
    assign wr_stat = req & wb_we_i & ack_q & wb_sel_i[0]
                     & (wb_adr_i == ADR_STAT);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                dat_q <= rd_mux(wb_adr_i, ctrl_q,
                                {oor_seen_q, ~drv_off_q,
                                 out_q.oor, locked}, out_q);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= apo_ctrl_t'(CTRL_RST);
        end else if (req && wb_we_i && ack_q && wb_sel_i[0]
                     && wb_adr_i == ADR_CTRL) begin
            ctrl_q <= apo_ctrl_t'(wb_dat_i[CTRL_W-1:0]); // see R16 R18
        end
    end

    // a flagged word arriving with the clear wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oor_seen_q <= 1'b0;
        end else if (upd_q && out_q.oor) begin
            oor_seen_q <= 1'b1;
        end else if (wr_stat && wb_dat_i[STAT_OOR_SEEN]) begin
            oor_seen_q <= 1'b0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ==========================================================
    // checks
    // ==========================================================
    a_clock_single: assert property ( // see R01
        !ctrl_q.clk_diff && !ctrl_q.pwr_down && $rose(clock_in_pos_i)
        |-> rise_evt) else $error("single-ended clock edge missed");

    a_sample_fall: assert property ( // see R02
        fall_evt |=> sample_q == $past(enc_w))
        else $error("sample not taken on clock fall");

    a_data_hold: assert property ( // see R03
        !$past(rise_evt) |-> $stable(out_q))
        else $error("output word changed without clock rise");

    a_pd_float: assert property ( // see R12
        $rose(ctrl_q.pwr_down) |=> drv_off_q && result_bus_oe_n_o)
        else $error("outputs not floated after power-down");

    a_pd_wake: assert property ( // see R13
        $fell(ctrl_q.pwr_down) |=> !drv_off_q && !result_bus_oe_n_o)
        else $error("outputs not driven after wake");

    a_strobe_float: assert property ( // see R14
        ctrl_q.pwr_down ##1 ctrl_q.pwr_down |-> data_valid_strobe_oe_n_o
        && $stable(conv_q)) else $error("strobe or clock active in pd");

    a_word_on_fall: assert property ( // see R06
        $changed(out_q) |-> !strobe_q)
        else $error("word changed while strobe high");

    a_dce_width: assert property ( // see R07
        ctrl_q.dce_en && stb_st_q == APO_STB_HIGH && rise_evt
        |=> !strobe_q ##1 (!strobe_q || rise_evt))
        else $error("equalised strobe pulse too short");

    a_lock_wait: assert property ( // see R05
        relock |=> !locked [*8])
        else $error("lock reported during relock");

    a_gray_zero: assert property ( // see R16 R19
        ctrl_q.gray_sel && analog_in_i == '0 |-> enc_w.code == 12'hC00)
        else $error("gray mid-scale code wrong");

    a_clamp_pos: assert property ( // see R10 R20 R17
        analog_in_i > POS_FS && !ctrl_q.gray_sel
        |-> enc_w.oor && enc_w.code == 12'h7FF)
        else $error("overrange not clamped");

    c_pd_cycle: cover property (
        $rose(drv_off_q) ##[1:300] $fell(drv_off_q));

    c_oor_out: cover property (upd_q && out_q.oor);

    c_gray_out: cover property (ctrl_q.gray_sel && upd_q);

    c_relock: cover property (relock ##[1:1000] (locked && ctrl_q.dce_en));

endmodule // apo_top
`default_nettype wire

// >>> dv/apo_capture_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// back-end capture logic
// ==============================
module apo_capture_model (
    input wire logic strobe_i,
    input wire logic conv_clk_i,
    input wire logic [apo_pkg::CODE_W-1:0] bus_i,
    input wire logic flag_i,
    output apo_pkg::apo_word_t stb_word_o,
    output apo_pkg::apo_word_t clk_word_o,
    output logic [15:0] stb_cnt_o
);
    import apo_pkg::*;

    initial stb_cnt_o = 16'h0000;

    // word and flag latched together
    always @(posedge strobe_i) begin
        stb_word_o <= '{oor: flag_i, code: bus_i};
        stb_cnt_o <= stb_cnt_o + 16'h0001;
    end

    // clock-edge capture lags the strobe capture by one word
    always @(posedge conv_clk_i) begin
        clk_word_o <= '{oor: flag_i, code: bus_i};
    end
endmodule // apo_capture_model
`default_nettype wire

// >>> dv/test_adc_parallel_output_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_parallel_output_interface;
    import apo_pkg::*;
    localparam int H = 4;
    // ==============================
    // signals
    // ==============================
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic pos = 1'b0;
    logic neg = 1'b0;
    logic signed [ANA_W-1:0] analog = '0;
    logic [CODE_W-1:0] bus, bus_line;
    logic bus_oe_n, flag, flag_oe_n, stb, stb_oe_n, flag_line, stb_line;
    apo_word_t stb_word;
    apo_word_t clk_word;
    logic [15:0] stb_cnt;
    apo_ctrl_t ctl = '0;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int low_n = 0;
    int k = 0;
    logic cap_ok = 1'b0;
    logic [12:0] samp = '0;
    logic [12:0] out_exp = '0;
    logic [12:0] prev_exp = '0;
    logic [12:0] p [8];
    logic [31:0] q;
    int corner [8] = '{0, -1, 2047, 2048, -2048, -2049, 8191, -8192};

    apo_top dut (
        .clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .clock_in_pos_i(pos), .clock_in_neg_i(neg),
        .analog_in_i(analog), .result_bus_o(bus),
        .result_bus_oe_n_o(bus_oe_n), .out_of_range_flag_o(flag),
        .out_of_range_flag_oe_n_o(flag_oe_n),
        .data_valid_strobe_o(stb),
        .data_valid_strobe_oe_n_o(stb_oe_n)
    );

    // floated lines show garbage, not the last value
    assign bus_line = bus_oe_n ? ~bus : bus;
    assign flag_line = flag_oe_n ? ~flag : flag;
    assign stb_line = stb_oe_n ? ~stb : stb;

    apo_capture_model back_end (
        .strobe_i(stb_line), .conv_clk_i(pos),
        .bus_i(bus_line), .flag_i(flag_line),
        .stb_word_o(stb_word), .clk_word_o(clk_word),
        .stb_cnt_o(stb_cnt)
    );

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ==============================
    // helpers
    // ==============================
    task automatic end_sim();
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", s, exp, seen);
        end
    endtask

    function automatic logic [12:0] enc(input int v, input logic g);
        logic [11:0] c;
        logic o;
        o = (v > 2047) || (v < -2048);
        c = (v > 2047) ? 12'h7ff : (v < -2048) ? 12'h800 : v[11:0];
        if (g) begin
            c = c ^ 12'h800;
            c = c ^ (c >> 1);
        end
        return {o, c};
    endfunction

    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n == 40) err_total++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input string s);
        wb(1'b0, a, '0);
        chk(s, q, e);
    endtask

    task automatic set_ctrl(input apo_ctrl_t c);
        wb(1'b1, ADR_CTRL, {28'h000_0000, c});
        ctl = c;
    endtask

    // nj holds the negative leg high for the whole period
    task automatic run(input int n, input logic nj);
        int v;
        logic live;
        for (int i = 0; i < n; i++) begin
            live = !ctl.pwr_down && !(ctl.clk_diff && nj);
            @(posedge clk_i);
            pos <= 1'b1;
            neg <= nj;
            if (live) begin
                out_exp = p[7];
                for (int j = 7; j > 0; j--) p[j] = p[j-1];
                p[0] = samp;
            end
            repeat (2) @(posedge clk_i);
            v = (k < 8) ? corner[k] : int'($urandom_range(4600)) - 2300;
            k++;
            analog <= v[ANA_W-1:0];
            repeat (H - 2) @(posedge clk_i);
            pos <= 1'b0;
            neg <= ctl.clk_diff | nj;
            if (live) samp = enc(v, ctl.gray_sel);
            repeat (H) @(posedge clk_i);
        end
    endtask

    // ==============================
    // monitors
    // ==============================
    always @(stb_cnt) begin
        if (cap_ok && stb_cnt != 0) begin
            chk("word", stb_word, out_exp);
            chk("clock word", clk_word, prev_exp);
            prev_exp = out_exp;
        end
    end

    always @(posedge clk_i) begin
        if (stb === 1'b0) begin
            low_n <= low_n + 1;
        end else begin
            if (low_n != 0 && cap_ok && !rst_i) begin
                chk("strobe low", low_n, ctl.dce_en ? 2 : H);
            end
            low_n <= 0;
        end
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    // ==============================
    // main sequence
    // ==============================
    initial begin
        q = $urandom(58);
        foreach (p[i]) p[i] = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        cap_ok = 1'b1;
        rd(ADR_CTRL, 32'h0000_0000, "ctrl reset");
        rd(ADR_STAT, 32'h0000_0005, "stat reset");
        rd(ADR_DATA, 32'h0000_0000, "data reset");
        wb(1'b1, 4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h0000_0000, "unmapped");
        // low byte disabled: the control write must not land
        wb_sel_i <= 4'he;
        wb(1'b1, ADR_CTRL, 32'h0000_000f);
        wb_sel_i <= 4'hf;
        rd(ADR_CTRL, 32'h0000_0000, "ctrl kept");
        run(30, 1'b0);
        run(4, 1'b1);
        rd(ADR_DATA, {19'h0_0000, out_exp}, "data reg");
        rd(ADR_STAT, {28'h0, 2'h3, out_exp[12], 1'b1}, "stat oor");
        wb(1'b1, ADR_STAT, 32'h0000_0008);
        rd(ADR_STAT, {28'h0, 2'h1, out_exp[12], 1'b1}, "stat clr");
        k = 0;
        set_ctrl(4'h4);
        run(24, 1'b0);
        set_ctrl(4'h5);
        rd(ADR_CTRL, 32'h0000_0005, "ctrl diff");
        run(16, 1'b0);
        run(4, 1'b1);
        run(12, 1'b0);
        set_ctrl(4'h2);
        run(50, 1'b0);
        wb(1'b0, ADR_STAT, '0);
        chk("lock early", q[0], 1'b0);
        run(110, 1'b0);
        wb(1'b0, ADR_STAT, '0);
        chk("lock done", q[0], 1'b1);
        cap_ok = 1'b0;
        set_ctrl(4'h8);
        @(posedge clk_i);
        #1;
        chk("oe_n off", {bus_oe_n, flag_oe_n, stb_oe_n}, 3'h7);
        wb(1'b0, ADR_STAT, '0);
        chk("stat drive", q[2], 1'b0);
        run(6, 1'b0);
        set_ctrl(4'h0);
        @(posedge clk_i);
        #1;
        chk("oe_n on", {bus_oe_n, flag_oe_n, stb_oe_n}, 3'h0);
        repeat (3) @(posedge clk_i);
        cap_ok = 1'b1;
        run(20, 1'b0);
        rd(ADR_DATA, {19'h0_0000, out_exp}, "data end");
        end_sim();
    end
endmodule // test_adc_parallel_output_interface
`default_nettype wire
